// [dv/can_bit_timing_config_chk.sv]
// port-level property checker for the bit-timing block
`timescale 1ns/1ps
`default_nettype none
`include "can_bit_timing_consts.vh"
module can_bit_timing_config_chk
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  // timing outputs
  input wire samplePoint,
  input wire bitStart,
  input wire sampledBit
);
  reg request_q;
  reg [3:0] reqCount_q;
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire mapped = (paddr[1:0] == 2'h0) && (paddr <= `ADDR_EVENTS);
  // the acknowledge lags the request, so only a long-held request counts as init mode
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      request_q <= 1'h1;
      reqCount_q <= 4'h0;
    end
    else
    begin
      if (acc && pwrite && paddr == `ADDR_CONTROL)
        request_q <= pwdata[0];
      reqCount_q <= !request_q ? 4'h0 :
                    (reqCount_q == 4'h8 ? reqCount_q : reqCount_q + 4'h1);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_err_map; acc && !mapped |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("no error on unmapped word");
  property p_err_ok; acc && mapped |-> !pslverr; endproperty
  a_err_ok: assert property (p_err_ok) else $error("error on mapped word");
  property p_rd_hi; rd |-> prdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_rd_unm; rd && !mapped |-> prdata == 32'h0; endproperty
  a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
  property p_init_ack; rd && paddr == `ADDR_STATUS && reqCount_q == 4'h8 |-> prdata[0]; endproperty
  a_init_ack: assert property (p_init_ack) else $error("acknowledge missing");
  property p_init_flg;
    rd && paddr == `ADDR_FLAGS && reqCount_q == 4'h8 |-> (prdata[7:0] & `FLG_W1C_MASK) == 8'h0;
  endproperty
  a_init_flg: assert property (p_init_flg) else $error("flags not held in init");
  property p_init_stop; reqCount_q == 4'h8 |-> !bitStart && !samplePoint; endproperty
  a_init_stop: assert property (p_init_stop) else $error("timing runs in init");
  property p_seq; bitStart |-> !samplePoint ##1 !samplePoint; endproperty
  a_seq: assert property (p_seq) else $error("sample point inside sync");
  property p_bit_chg; $changed(sampledBit) |-> $past(samplePoint, 2); endproperty
  a_bit_chg: assert property (p_bit_chg) else $error("bit value moved off sample");
endmodule // can_bit_timing_config_chk
bind can_bit_timing_config can_bit_timing_config_chk can_bit_timing_config_chk_inst
(
  .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .samplePoint, .bitStart, .sampledBit
);
`default_nettype wire

// [dv/can_bit_timing_config_test.sv]
// self-checking bench for the bit-timing block
`timescale 1ns/1ps
`default_nettype none
`include "can_bit_timing_consts.vh"
module can_bit_timing_config_test;
  reg clk_sys = 1'h0;
  reg rst = 1'h1;
  reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] evt = 4'h0;
  reg [1:0] rxState = 2'h0, txState = 2'h0;
  reg txLevel = 1'h1;
  wire pready, pslverr, tqTick, samplePoint, bitStart, sampledBit, receiveIrq, canRx;
  wire [31:0] prdata;
  int fails = 0, compares = 0, cycles = 0, seed = 32'h038F;
  int presc, t1, t2, s, n, i, j;
  reg [31:0] d, pre, seg;
  reg e;
  reg [7:0] stat, m;
  can_bit_timing_config can_bit_timing_config_inst
  (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .wakeupEvent(evt[3]), .statusChangeEvent(evt[2]), .overrunEvent(evt[1]),
    .receiveFullEvent(evt[0]), .receiverStateIn(rxState), .transmitterStateIn(txState),
    .canRx, .tqTick, .samplePoint, .bitStart, .sampledBit, .receiveIrq
  );
  can_bus_node can_bus_node_inst (.clk_sys, .rst, .txLevel, .canRx);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string name);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1)
      @(posedge clk_sys);
    d = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdchk(input [11:0] a, input [31:0] exp, input string name);
    apb(1'h0, a, 32'h0);
    chk(d, exp, name);
  endtask
  task setInit(input v);
    apb(1'h1, `ADDR_CONTROL, {31'h0, v});
    do
      apb(1'h0, `ADDR_STATUS, 32'h0);
    while (d[0] !== v);
  endtask
  // clocks from one pulse to the next, sampled clear of the launching edge
  task gap(input b);
    @(negedge clk_sys);
    while ((b ? bitStart : tqTick) !== 1'h1)
      @(negedge clk_sys);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while ((b ? bitStart : tqTick) !== 1'h1);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    rdchk(`ADDR_SEGMENTS, 32'h0, "segments");
    rdchk(`ADDR_FLAGS, 32'h0, "flags");
    rdchk(12'h020, 32'h0, "unmapped");
    chk(e, 1'h1, "slverr");
    for (i = 0; i < 2; i++)
    begin
      setInit(1'h1);
      // prescale kept at one or more so quantum pulses stay apart
      presc = 1 + $unsigned($random(seed)) % 3;
      s = $unsigned($random(seed)) % 4;
      t1 = 2 + $unsigned($random(seed)) % 6;
      t2 = 1 + $unsigned($random(seed)) % 6;
      pre = s * 64 + presc;
      seg = i * 128 + t2 * 16 + t1;
      apb(1'h1, `ADDR_PRESCALE, pre);
      apb(1'h1, `ADDR_SEGMENTS, seg);
      rdchk(`ADDR_PRESCALE, pre, "prescale");
      rdchk(`ADDR_SEGMENTS, seg, "segments");
      rdchk(`ADDR_FLAGS, 32'h0, "flags in init");
      setInit(1'h0);
      apb(1'h1, `ADDR_SEGMENTS, 32'hFF);
      rdchk(`ADDR_SEGMENTS, seg, "locked");
      gap(1'h0);
      chk(n, presc + 1, "quantum");
      gap(1'h1);
      chk(n, (presc + 1) * (t1 + t2 + 3), "bit time");
      // sample point closes segment one, counted from the pulse that ends the sync quantum
      n = 0;
      do
      begin
        @(negedge clk_sys);
        n++;
      end
      while (samplePoint !== 1'h1);
      chk(n, (presc + 1) * (t1 + 1), "sample point");
      for (j = 0; j < 2; j++)
      begin
        txLevel <= j;
        repeat (3) gap(1'h1);
        chk(sampledBit, j, "bit value");
      end
    end
    @(posedge clk_sys);
    rxState <= 2'h2;
    txState <= 2'h1;
    stat = 8'h24;
    for (i = 0; i < 4; i++)
    begin
      m = i < 2 ? 8'h01 << i : 8'h40 << (i - 2);
      @(posedge clk_sys);
      evt <= 4'h1 << i;
      apb(1'h1, `ADDR_FLAGS, {24'h0, m});
      rdchk(`ADDR_FLAGS, {24'h0, stat | m}, "held");
      evt <= 4'h0;
      apb(1'h1, `ADDR_FLAGS, 32'h0);
      rdchk(`ADDR_FLAGS, {24'h0, stat | m}, "zero write");
      @(negedge clk_sys);
      chk(receiveIrq, 1'h0, "masked");
      apb(1'h1, `ADDR_ENABLES, {24'h0, m});
      repeat (2) @(negedge clk_sys);
      chk(receiveIrq, 1'h1, "irq");
      apb(1'h1, `ADDR_FLAGS, 32'hFF);
      rdchk(`ADDR_FLAGS, {24'h0, stat}, "cleared");
      repeat (2) @(negedge clk_sys);
      chk(receiveIrq, 1'h0, "irq off");
    end
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    rdchk(`ADDR_SEGMENTS, 32'h0, "segments again");
    rdchk(`ADDR_PRESCALE, 32'h0, "prescale again");
    report_and_stop;
  end
endmodule // can_bit_timing_config_test
`default_nettype wire

// [dv/can_bus_node.sv]
// another node driving the receive line through its transceiver
`timescale 1ns/1ps
`default_nettype none
module can_bus_node
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // level asked for by the bench, 1 is recessive
  input wire txLevel,
  // bus level seen by the receiver
  output logic canRx
);
  // recessive through reset, as an idle terminated bus would be
  always @(posedge clk_sys)
    canRx <= rst ? 1'h1 : txLevel;
endmodule // can_bus_node
`default_nettype wire

// [verilog/can_bit_sampler.v]
// three-tap bus sampler with single or majority bit decision
`timescale 1ns/1ps
`default_nettype none
module can_bit_sampler
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // control
  input wire tqTick,
  input wire atSample,
  input wire tripleSel,
  input wire busLevel,
  // result
  output reg bitValue
);
  reg tap1_q;
  reg tap2_q;
  wire majority;

  // taps move once per quantum so the three samples span the last quanta before the sample point
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tap1_q <= 1'b1;
      tap2_q <= 1'b1;
    end
    else if (tqTick)
    begin
      tap1_q <= busLevel;
      tap2_q <= tap1_q;
    end
  end

  assign majority = (tap1_q & tap2_q) | (tap1_q & busLevel) | (tap2_q & busLevel);

  always @(posedge clk_sys)
  begin
    if (rst)
      bitValue <= 1'b1;
    else if (atSample)
      bitValue <= tripleSel ? majority : busLevel;
  end
endmodule // can_bit_sampler
`default_nettype wire

// [verilog/can_bit_timing_config.v]
// CAN bit-timing registers, receive flags and quantum/bit timing engine
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "can_bit_timing_consts.vh"
module can_bit_timing_config
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // events from the protocol engine
  input wire wakeupEvent,
  input wire statusChangeEvent,
  input wire overrunEvent,
  input wire receiveFullEvent,
  input wire [1:0] receiverStateIn,
  input wire [1:0] transmitterStateIn,
  // can bus
  input wire canRx,
  // timing outputs and receive interrupt
  output reg tqTick,
  output reg samplePoint,
  output reg bitStart,
  output reg sampledBit,
  output reg receiveIrq
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [7:0] prescale_q;
  reg [7:0] segments_q;
  reg [7:0] flags_q;
  reg [7:0] enables_q;
  reg initRequest_q;
  reg initAck_q;
  reg [3:0] causeLive_q;
  wire initActive;
  wire wrStrobe;
  wire addrHit;

  assign initActive = initRequest_q & initAck_q;
  assign pready = 1'b1;
  assign addrHit = (paddr[1:0] == 2'h0) && (paddr <= `ADDR_EVENTS);
  assign pslverr = psel & penable & ~addrHit;
  assign wrStrobe = psel & penable & pwrite;

  // ----------------------------------------------------------------
  // control and timing registers
  // ----------------------------------------------------------------
  // acknowledge follows the request one cycle later, giving the handshake
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      initRequest_q <= `RST_CONTROL;
      initAck_q <= 1'b0;
      prescale_q <= `RST_PRESCALE;
      segments_q <= `RST_SEGMENTS;
      enables_q <= `RST_ENABLES;
    end
    else
    begin
      initAck_q <= initRequest_q;
      if (wrStrobe && paddr == `ADDR_CONTROL)
        initRequest_q <= pwdata[`CTL_INIT_REQ_BIT];
      if (wrStrobe && paddr == `ADDR_PRESCALE && initActive)
        prescale_q <= pwdata[7:0];
      if (wrStrobe && paddr == `ADDR_SEGMENTS && initActive)
        segments_q <= pwdata[7:0];
      if (wrStrobe && paddr == `ADDR_ENABLES)
        enables_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // receive flags
  // ----------------------------------------------------------------
  // cause bits mirror the live event levels so a clear cannot drop a live condition
  wire [3:0] causeNow;
  wire [7:0] clearReq;
  wire flagWrite;
  reg [7:0] flags_d;
  assign causeNow = {wakeupEvent, statusChangeEvent, overrunEvent, receiveFullEvent};
  assign flagWrite = wrStrobe && paddr == `ADDR_FLAGS && !initActive;
  assign clearReq = flagWrite ? (pwdata[7:0] & `FLG_W1C_MASK) : 8'h00;

  always @*
  begin
    flags_d = flags_q;
    // a clear is refused while its cause still stands
    if (clearReq[`FLG_WAKE_BIT] && !causeLive_q[3])
      flags_d[`FLG_WAKE_BIT] = 1'b0;
    if (clearReq[`FLG_CSC_BIT] && !causeLive_q[2])
      flags_d[`FLG_CSC_BIT] = 1'b0;
    if (clearReq[`FLG_OVR_BIT] && !causeLive_q[1])
      flags_d[`FLG_OVR_BIT] = 1'b0;
    if (clearReq[`FLG_RXF_BIT] && !causeLive_q[0])
      flags_d[`FLG_RXF_BIT] = 1'b0;
    // set beats clear
    if (wakeupEvent)
      flags_d[`FLG_WAKE_BIT] = 1'b1;
    if (statusChangeEvent)
      flags_d[`FLG_CSC_BIT] = 1'b1;
    if (overrunEvent)
      flags_d[`FLG_OVR_BIT] = 1'b1;
    if (receiveFullEvent)
      flags_d[`FLG_RXF_BIT] = 1'b1;
    // status fields freeze while a status change is pending
    if (!flags_q[`FLG_CSC_BIT])
    begin
      flags_d[`FLG_RST_HI:`FLG_RST_LO] = receiverStateIn;
      flags_d[`FLG_TST_HI:`FLG_TST_LO] = transmitterStateIn;
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      flags_q <= `RST_FLAGS;
      causeLive_q <= 4'h0;
    end
    else if (initActive)
    begin
      // event flags held in reset, status fields unaffected
      flags_q <= flags_d & `FLG_RO_MASK;
      causeLive_q <= 4'h0;
    end
    else
    begin
      flags_q <= flags_d;
      causeLive_q <= causeNow;
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
      receiveIrq <= 1'b0;
    else
      receiveIrq <= |(flags_q & enables_q & `FLG_W1C_MASK);
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `ADDR_CONTROL: prdata <= {31'h00000000, initRequest_q};
        `ADDR_STATUS: prdata <= {31'h00000000, initAck_q};
        `ADDR_PRESCALE: prdata <= {24'h000000, prescale_q};
        `ADDR_SEGMENTS: prdata <= {24'h000000, segments_q};
        `ADDR_FLAGS: prdata <= {24'h000000, flags_q};
        `ADDR_ENABLES: prdata <= {24'h000000, enables_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // quantum prescaler
  // ----------------------------------------------------------------
  wire [5:0] prescaleField;
  reg [5:0] preCount_q;
  assign prescaleField = prescale_q[`PRESCALER_HI:`PRESCALER_LO];

  // divide by field plus one: count down from field, tick at zero
  always @(posedge clk_sys)
  begin
    if (rst || initActive)
    begin
      preCount_q <= 6'h00;
      tqTick <= 1'b0;
    end
    else if (preCount_q == 6'h00)
    begin
      preCount_q <= prescaleField;
      tqTick <= 1'b1;
    end
    else
    begin
      preCount_q <= preCount_q - 6'h01;
      tqTick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus input synchroniser and edge detection
  // ----------------------------------------------------------------
  reg rxMeta_q;
  reg rxSync_q;
  reg rxPrev_q;
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end
    else
    begin
      rxMeta_q <= canRx;
      rxSync_q <= rxMeta_q;
      if (tqTick)
        rxPrev_q <= rxSync_q;
    end
  end

  // only one resynchronisation per bit, on a recessive-to-dominant edge
  wire fallEdge;
  assign fallEdge = tqTick & rxPrev_q & ~rxSync_q;

  // ----------------------------------------------------------------
  // bit timing state machine
  // ----------------------------------------------------------------
  localparam [1:0] ST_SYNC = 2'b00;
  localparam [1:0] ST_SEG1 = 2'b01;
  localparam [1:0] ST_SEG2 = 2'b10;

  reg [1:0] state_q;
  reg [4:0] tqCount_q;
  reg [4:0] seg1Len_q;
  reg [3:0] seg2Len_q;
  reg edgeSeen_q;
  wire [4:0] seg1Base;
  wire [3:0] seg2Base;
  wire [2:0] jumpWidth;
  wire [4:0] lateErr;
  wire [3:0] earlyRoom;
  wire [2:0] lengthen;
  wire [3:0] shortenTo;

  assign seg1Base = {1'b0, segments_q[`TS1_HI:`TS1_LO]} + 5'h01;
  assign seg2Base = {1'b0, segments_q[`TS2_HI:`TS2_LO]} + 4'h1;
  assign jumpWidth = {1'b0, prescale_q[`JUMP_HI:`JUMP_LO]} + 3'h1;
  // phase error in seg1 is quanta already elapsed; clip to jump width
  assign lateErr = tqCount_q;
  assign lengthen = (lateErr > {2'b00, jumpWidth}) ? jumpWidth : lateErr[2:0];
  assign earlyRoom = seg2Len_q - tqCount_q[3:0];
  assign shortenTo = (earlyRoom > {1'b0, jumpWidth}) ?
                     (seg2Len_q - {1'b0, jumpWidth}) : tqCount_q[3:0];

  always @(posedge clk_sys)
  begin
    if (rst || initActive)
    begin
      state_q <= ST_SYNC;
      tqCount_q <= 5'h00;
      seg1Len_q <= 5'h01;
      seg2Len_q <= 4'h1;
      edgeSeen_q <= 1'b0;
      samplePoint <= 1'b0;
      bitStart <= 1'b0;
    end
    else
    begin
      samplePoint <= 1'b0;
      bitStart <= 1'b0;
      if (tqTick)
      begin
        case (state_q)
          ST_SYNC:
          begin
            // one synchronisation quantum opens each bit
            state_q <= ST_SEG1;
            tqCount_q <= 5'h00;
            seg1Len_q <= seg1Base;
            seg2Len_q <= seg2Base;
            edgeSeen_q <= fallEdge;
            bitStart <= 1'b1;
          end
          ST_SEG1:
          begin
            if (fallEdge && !edgeSeen_q)
            begin
              seg1Len_q <= seg1Len_q + {2'b00, lengthen};
              edgeSeen_q <= 1'b1;
            end
            if (tqCount_q + 5'h01 >= seg1Len_q)
            begin
              // sample point closes segment one
              state_q <= ST_SEG2;
              tqCount_q <= 5'h00;
              samplePoint <= 1'b1;
            end
            else
              tqCount_q <= tqCount_q + 5'h01;
          end
          ST_SEG2:
          begin
            if (fallEdge && !edgeSeen_q)
            begin
              // early edge: cut segment two short by up to the jump width
              seg2Len_q <= shortenTo;
              edgeSeen_q <= 1'b1;
            end
            if ({1'b0, tqCount_q[3:0]} + 5'h01 >= {1'b0, seg2Len_q})
            begin
              state_q <= ST_SYNC;
              tqCount_q <= 5'h00;
            end
            else
              tqCount_q <= tqCount_q + 5'h01;
          end
          default: state_q <= ST_SYNC;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // bit value
  // ----------------------------------------------------------------
  wire bitValue;
  can_bit_sampler can_bit_sampler_inst
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .tqTick(tqTick),
    .atSample(samplePoint),
    .tripleSel(segments_q[`TRIPLE_BIT]),
    .busLevel(rxSync_q),
    .bitValue(bitValue)
  );

  always @(posedge clk_sys)
  begin
    if (rst)
      sampledBit <= 1'b1;
    else
      sampledBit <= bitValue;
  end
endmodule // can_bit_timing_config
`default_nettype wire

// [verilog/can_bit_timing_consts.vh]
// register map, field layout, reset values and flag masks of the bit-timing block
`ifndef CAN_BIT_TIMING_CONSTS_VH
`define CAN_BIT_TIMING_CONSTS_VH
// register indices of the module map
`define IDX_CONTROL 10'h000
`define IDX_STATUS 10'h001
`define IDX_PRESCALE 10'h002
`define IDX_SEGMENTS 10'h003
`define IDX_FLAGS 10'h004
`define IDX_ENABLES 10'h005
`define IDX_EVENTS 10'h006
// byte addresses on the register bus: one aligned word per register, four times the index
`define ADDR_CONTROL {`IDX_CONTROL, 2'h0}
`define ADDR_STATUS {`IDX_STATUS, 2'h0}
`define ADDR_PRESCALE {`IDX_PRESCALE, 2'h0}
`define ADDR_SEGMENTS {`IDX_SEGMENTS, 2'h0}
`define ADDR_FLAGS {`IDX_FLAGS, 2'h0}
`define ADDR_ENABLES {`IDX_ENABLES, 2'h0}
`define ADDR_EVENTS {`IDX_EVENTS, 2'h0}
// field positions
`define JUMP_HI 7
`define JUMP_LO 6
`define PRESCALER_HI 5
`define PRESCALER_LO 0
`define TRIPLE_BIT 7
`define TS2_HI 6
`define TS2_LO 4
`define TS1_HI 3
`define TS1_LO 0
`define CTL_INIT_REQ_BIT 0
`define FLG_WAKE_BIT 7
`define FLG_CSC_BIT 6
`define FLG_RST_HI 5
`define FLG_RST_LO 4
`define FLG_TST_HI 3
`define FLG_TST_LO 2
`define FLG_OVR_BIT 1
`define FLG_RXF_BIT 0
// reset values
`define RST_PRESCALE 8'h00
`define RST_SEGMENTS 8'h00
`define RST_FLAGS 8'h00
`define RST_ENABLES 8'h00
// only the init request bit of the control word is stored
`define RST_CONTROL 1'h1
// read-only status bits of the flag register, and the clearable ones
`define FLG_W1C_MASK 8'hC3
`define FLG_RO_MASK 8'h3C
`endif
